// ### etss_defs.vh
`ifndef ETSS_DEFS_VH
`define ETSS_DEFS_VH

// Thread control record word offsets (byte addresses)
`define ETSS_OFF_RSV_LO 8'h00
`define ETSS_OFF_RSV_HI 8'h04
`define ETSS_OFF_FLAGS_LO 8'h08
`define ETSS_OFF_FLAGS_HI 8'h0C
`define ETSS_OFF_SAVE_STACK_OFFSET_LO 8'h10
`define ETSS_OFF_SAVE_STACK_OFFSET_HI 8'h14
`define ETSS_OFF_CIDX 8'h18
`define ETSS_OFF_NCNT 8'h1C
`define ETSS_OFF_OENT_LO 8'h20
`define ETSS_OFF_OENT_HI 8'h24
`define ETSS_OFF_AEP_LO 8'h28
`define ETSS_OFF_AEP_HI 8'h2C
`define ETSS_OFF_OFS_LO 8'h30
`define ETSS_OFF_OFS_HI 8'h34
`define ETSS_OFF_OGS_LO 8'h38
`define ETSS_OFF_OGS_HI 8'h3C
`define ETSS_OFF_FSLIM 8'h40
`define ETSS_OFF_GSLIM 8'h44

// Enclave context and status words
`define ETSS_OFF_EBASE_LO 8'h80
`define ETSS_OFF_EBASE_HI 8'h84
`define ETSS_OFF_FPAGES 8'h88
`define ETSS_OFF_ATTR 8'h8C
`define ETSS_OFF_MCAP 8'h90
`define ETSS_OFF_MSIZE 8'h94
`define ETSS_OFF_XSIZE 8'h98
`define ETSS_OFF_STATUS 8'h9C
`define ETSS_OFF_FADDR_LO 8'hA0
`define ETSS_OFF_FADDR_HI 8'hA4
`define ETSS_OFF_RBASE_LO 8'hA8
`define ETSS_OFF_RBASE_HI 8'hAC

// Field positions
`define ETSS_FLAG_DBG_OPT_IN 0
`define ETSS_ATTR_DEBUG 1
`define ETSS_ATTR_MODE64 2
`define ETSS_ATTR_W 6
`define ETSS_ST_ENTRY_FAIL 0
`define ETSS_ST_MISALIGN 1
`define ETSS_ST_OVERLAP 2
`define ETSS_ST_RESUME_FAIL 3
`define ETSS_ST_DBG_DENIED 4
`define ETSS_ST_W 5

// Layout constants
`define ETSS_PAGE_SHIFT 12
`define ETSS_PAGE_MASK 64'h0000_0000_0000_0FFF
`define ETSS_GPR_SIZE 64'h0000_0000_0000_00B0

// Reset values
`define ETSS_RST_64 64'h0000_0000_0000_0000
`define ETSS_RST_32 32'h0000_0000
`define ETSS_RST_FPAGES 32'h0000_0001

`endif

// ### etss_frame_calc.v
`timescale 1ns/1ps
`include "etss_defs.vh"

module etss_frame_calc (
    // Enclave and record context
    input wire [63:0] ebase_i,
    input wire [63:0] save_stack_offset_i,
    input wire [31:0] cidx_i,
    input wire [31:0] fpages_i,
    // Region sizing
    input wire [31:0] mcap_i,
    input wire [31:0] msize_i,
    input wire [31:0] xsize_i,
    // Region addresses
    output wire [63:0] frame_o,
    output wire [63:0] gpr_o,
    output wire [63:0] misc_o,
    output wire misc_valid_o,
    output wire overlap_o
);

    wire [63:0] prod;
    wire [63:0] fbytes;
    wire [63:0] low_end;

    // Index times frame pages, scaled to bytes
    assign prod = {32'h0000_0000, cidx_i} * {32'h0000_0000, fpages_i};
    assign fbytes = prod << `ETSS_PAGE_SHIFT;
    // Frame base inside the save stack
    assign frame_o = ebase_i + save_stack_offset_i + fbytes;
    // General-register region ends flush with the frame top
    assign gpr_o = frame_o + ({32'h0000_0000, fpages_i} << `ETSS_PAGE_SHIFT) - `ETSS_GPR_SIZE;
    // Misc region sits right below, only if capability is nonzero
    assign misc_valid_o = |mcap_i;
    assign misc_o = misc_valid_o ? gpr_o - {32'h0000_0000, msize_i} : gpr_o;
    // Extended state must not run into the upper regions
    assign low_end = frame_o + {32'h0000_0000, xsize_i};
    assign overlap_o = low_end > misc_o;

endmodule

// ### etss_seg_calc.v
`timescale 1ns/1ps
`include "etss_defs.vh"

module etss_seg_calc (
    // Enclave base and record offsets
    input wire [63:0] ebase_i,
    input wire [63:0] oent_i,
    input wire [63:0] ofs_i,
    input wire [63:0] ogs_i,
    input wire [63:0] save_stack_offset_i,
    // Derived addresses
    output wire [63:0] entry_o,
    output wire [63:0] fs_o,
    output wire [63:0] gs_o,
    output wire misalign_o
);

    // Entry point and segment bases relative to the enclave base
    assign entry_o = ebase_i + oent_i;
    assign fs_o = ebase_i + ofs_i;
    assign gs_o = ebase_i + ogs_i;
    // Page alignment of the segment and save-stack offsets is software's duty; flag slips
    assign misalign_o = |((ofs_i | ogs_i | save_stack_offset_i) & `ETSS_PAGE_MASK);

endmodule

// ### etss_thread_ctl.v
`timescale 1ns/1ps
`include "etss_defs.vh"

module etss_thread_ctl (
    // Clock and reset
    input wire MCLK_I,
    input wire RST_B_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // Core operation strobes
    input wire ENTRY_OP_I,
    input wire RESUME_OP_I,
    input wire AEX_OP_I,
    input wire PAGE_ADD_OP_I,
    input wire PAGE_ACCEPT_OP_I,
    input wire DEBUG_READ_OP_I,
    input wire [63:0] AEP_I,
    // Entry results
    output reg ENTRY_OK_O,
    output reg ENTRY_FAIL_O,
    output reg [63:0] ENTRY_ADDR_O,
    output reg [63:0] FS_BASE_O,
    output reg [63:0] GS_BASE_O,
    output reg [31:0] FS_LIMIT_O,
    output reg [31:0] GS_LIMIT_O,
    output reg LIMIT_LOAD_O,
    output reg DEBUG_EN_O,
    // State save and resume
    output reg SAVE_O,
    output reg [63:0] EXTENDED_STATE_REGION_ADDR_O,
    output reg [63:0] MISC_ADDR_O,
    output reg MISC_VALID_O,
    output reg [63:0] GPR_ADDR_O,
    output reg RESUME_OK_O,
    output reg RESUME_FAIL_O,
    // Debug read
    output reg [63:0] DBG_RDATA_O,
    output reg DBG_RVALID_O,
    output reg DBG_RERR_O
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    reg dbg_opt_in;
    reg [63:0] save_stack_offset;
    reg [31:0] cidx;
    reg [31:0] ncnt;
    reg [63:0] oent;
    reg [63:0] async_exit_pointer;
    reg [63:0] ofs;
    reg [63:0] ogs;
    reg [31:0] fslim;
    reg [31:0] gslim;
    reg [63:0] ebase;
    reg [31:0] fpages;
    reg [`ETSS_ATTR_W-1:0] attr;
    reg [31:0] mcap;
    reg [31:0] msize;
    reg [31:0] xsize;
    reg [51:0] rbase;
    reg [`ETSS_ST_W-1:0] status;

    reg [31:0] rd_data;
    reg rd_hit;

    wire [63:0] frame_addr;
    wire [63:0] gpr_addr;
    wire [63:0] misc_addr;
    wire misc_valid;
    wire overlap;
    wire [63:0] entry_addr;
    wire [63:0] fs_base;
    wire [63:0] gs_base;
    wire misalign;

    // Completing access edge; writes land only here
    wire acc = PSEL_I & PENABLE_I & PREADY_O;
    wire wr = acc & PWRITE_I & ~PSLVERR_O;
    wire dbg_attr = attr[`ETSS_ATTR_DEBUG];
    wire mode32 = ~attr[`ETSS_ATTR_MODE64];
    wire add_op = PAGE_ADD_OP_I | PAGE_ACCEPT_OP_I;
    wire entry_ok = ENTRY_OP_I & (cidx < ncnt);
    wire resume_ok = RESUME_OP_I & (cidx != `ETSS_RST_32);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Replace one half of a 64-bit field
    function [63:0] put_half;
        input [63:0] old;
        input hi;
        input [31:0] d;
        begin
            put_half = hi ? {d, old[31:0]} : {old[63:32], d};
        end
    endfunction

    // Pick one half of a 64-bit field
    function [31:0] get_half;
        input [63:0] v;
        input hi;
        begin
            get_half = hi ? v[63:32] : v[31:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address arithmetic

    etss_frame_calc u_frame (
        .ebase_i(ebase),
        .save_stack_offset_i(save_stack_offset),
        .cidx_i(cidx),
        .fpages_i(fpages),
        .mcap_i(mcap),
        .msize_i(msize),
        .xsize_i(xsize),
        .frame_o(frame_addr),
        .gpr_o(gpr_addr),
        .misc_o(misc_addr),
        .misc_valid_o(misc_valid),
        .overlap_o(overlap)
    );

    etss_seg_calc u_seg (
        .ebase_i(ebase),
        .oent_i(oent),
        .ofs_i(ofs),
        .ogs_i(ogs),
        .save_stack_offset_i(save_stack_offset),
        .entry_o(entry_addr),
        .fs_o(fs_base),
        .gs_o(gs_base),
        .misalign_o(misalign)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read decode

    // Reserved high halves read zero; unknown offsets raise an error
    always @* begin
        rd_data = `ETSS_RST_32;
        rd_hit = 1'b1;
        case (PADDR_I)
            `ETSS_OFF_RSV_LO, `ETSS_OFF_RSV_HI, `ETSS_OFF_FLAGS_HI: rd_data = `ETSS_RST_32;
            `ETSS_OFF_FLAGS_LO: rd_data = {31'h0000_0000, dbg_opt_in};
            `ETSS_OFF_SAVE_STACK_OFFSET_LO, `ETSS_OFF_SAVE_STACK_OFFSET_HI: rd_data = get_half(save_stack_offset, PADDR_I[2]);
            `ETSS_OFF_CIDX: rd_data = cidx;
            `ETSS_OFF_NCNT: rd_data = ncnt;
            `ETSS_OFF_OENT_LO, `ETSS_OFF_OENT_HI: rd_data = get_half(oent, PADDR_I[2]);
            `ETSS_OFF_AEP_LO, `ETSS_OFF_AEP_HI: rd_data = get_half(async_exit_pointer, PADDR_I[2]);
            `ETSS_OFF_OFS_LO, `ETSS_OFF_OFS_HI: rd_data = get_half(ofs, PADDR_I[2]);
            `ETSS_OFF_OGS_LO, `ETSS_OFF_OGS_HI: rd_data = get_half(ogs, PADDR_I[2]);
            `ETSS_OFF_FSLIM: rd_data = fslim;
            `ETSS_OFF_GSLIM: rd_data = gslim;
            `ETSS_OFF_EBASE_LO, `ETSS_OFF_EBASE_HI: rd_data = get_half(ebase, PADDR_I[2]);
            `ETSS_OFF_FPAGES: rd_data = fpages;
            `ETSS_OFF_ATTR: rd_data = {26'h000_0000, attr};
            `ETSS_OFF_MCAP: rd_data = mcap;
            `ETSS_OFF_MSIZE: rd_data = msize;
            `ETSS_OFF_XSIZE: rd_data = xsize;
            `ETSS_OFF_STATUS: rd_data = {27'h000_0000, status};
            `ETSS_OFF_FADDR_LO, `ETSS_OFF_FADDR_HI: rd_data = get_half(frame_addr, PADDR_I[2]);
            `ETSS_OFF_RBASE_LO: rd_data = {rbase[19:0], 12'h000};
            `ETSS_OFF_RBASE_HI: rd_data = rbase[51:20];
            default: rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: no wait states, data and error from flops

    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= `ETSS_RST_32;
        end else begin
            PREADY_O <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & ~rd_hit;
            // Setup phase captures read data for the access phase
            if (PSEL_I && !PENABLE_I) begin
                PRDATA_O <= (PWRITE_I || !rd_hit) ? `ETSS_RST_32 : rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-writable record and context fields

    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            save_stack_offset <= `ETSS_RST_64;
            ncnt <= `ETSS_RST_32;
            oent <= `ETSS_RST_64;
            ofs <= `ETSS_RST_64;
            ogs <= `ETSS_RST_64;
            fslim <= `ETSS_RST_32;
            gslim <= `ETSS_RST_32;
            ebase <= `ETSS_RST_64;
            fpages <= `ETSS_RST_FPAGES;
            attr <= {`ETSS_ATTR_W{1'b0}};
            mcap <= `ETSS_RST_32;
            msize <= `ETSS_RST_32;
            xsize <= `ETSS_RST_32;
            rbase <= 52'h0_0000_0000_0000;
        end else if (wr) begin
            case (PADDR_I)
                `ETSS_OFF_SAVE_STACK_OFFSET_LO, `ETSS_OFF_SAVE_STACK_OFFSET_HI: save_stack_offset <= put_half(save_stack_offset, PADDR_I[2], PWDATA_I);
                `ETSS_OFF_NCNT: ncnt <= PWDATA_I;
                `ETSS_OFF_OENT_LO, `ETSS_OFF_OENT_HI: oent <= put_half(oent, PADDR_I[2], PWDATA_I);
                `ETSS_OFF_OFS_LO, `ETSS_OFF_OFS_HI: ofs <= put_half(ofs, PADDR_I[2], PWDATA_I);
                `ETSS_OFF_OGS_LO, `ETSS_OFF_OGS_HI: ogs <= put_half(ogs, PADDR_I[2], PWDATA_I);
                `ETSS_OFF_FSLIM: fslim <= PWDATA_I;
                `ETSS_OFF_GSLIM: gslim <= PWDATA_I;
                `ETSS_OFF_EBASE_LO, `ETSS_OFF_EBASE_HI: ebase <= put_half(ebase, PADDR_I[2], PWDATA_I);
                // Zero pages would collapse the frame; keep at least one
                `ETSS_OFF_FPAGES: fpages <= (PWDATA_I == `ETSS_RST_32) ? `ETSS_RST_FPAGES : PWDATA_I;
                `ETSS_OFF_ATTR: attr <= PWDATA_I[`ETSS_ATTR_W-1:0];
                `ETSS_OFF_MCAP: mcap <= PWDATA_I;
                `ETSS_OFF_MSIZE: msize <= PWDATA_I;
                `ETSS_OFF_XSIZE: xsize <= PWDATA_I;
                // Low 12 address bits do not exist: page-aligned record
                `ETSS_OFF_RBASE_LO: rbase[19:0] <= PWDATA_I[31:12];
                `ETSS_OFF_RBASE_HI: rbase[51:20] <= PWDATA_I;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fields that hardware also writes; hardware wins a same-cycle clash

    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            cidx <= `ETSS_RST_32;
            dbg_opt_in <= 1'b0;
            async_exit_pointer <= `ETSS_RST_64;
        end else begin
            // Frame index: add/accept, exit, resume, then software
            if (add_op) begin
                cidx <= `ETSS_RST_32;
            end else if (AEX_OP_I) begin
                cidx <= cidx + 32'h0000_0001;
            end else if (resume_ok) begin
                cidx <= cidx - 32'h0000_0001;
            end else if (wr && PADDR_I == `ETSS_OFF_CIDX) begin
                cidx <= PWDATA_I;
            end
            // Opt-in flag: cleared on add, debugger may set with debug attribute
            if (PAGE_ADD_OP_I) begin
                dbg_opt_in <= 1'b0;
            end else if (wr && PADDR_I == `ETSS_OFF_FLAGS_LO && dbg_attr) begin
                dbg_opt_in <= PWDATA_I[`ETSS_FLAG_DBG_OPT_IN];
            end
            // Exit pointer captured at entry
            if (entry_ok) begin
                async_exit_pointer <= AEP_I;
            end else if (wr && (PADDR_I == `ETSS_OFF_AEP_LO || PADDR_I == `ETSS_OFF_AEP_HI)) begin
                async_exit_pointer <= put_half(async_exit_pointer, PADDR_I[2], PWDATA_I);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status: sticky, write one to clear, set beats clear

    wire [`ETSS_ST_W-1:0] st_set = {
        DEBUG_READ_OP_I & ~dbg_attr,
        RESUME_OP_I & ~resume_ok,
        overlap,
        misalign,
        ENTRY_OP_I & ~entry_ok
    };
    wire [`ETSS_ST_W-1:0] st_clr = (wr && PADDR_I == `ETSS_OFF_STATUS) ? PWDATA_I[`ETSS_ST_W-1:0] :
                                   {`ETSS_ST_W{1'b0}};

    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            status <= {`ETSS_ST_W{1'b0}};
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Thread entry outputs

    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            ENTRY_OK_O <= 1'b0;
            ENTRY_FAIL_O <= 1'b0;
            ENTRY_ADDR_O <= `ETSS_RST_64;
            FS_BASE_O <= `ETSS_RST_64;
            GS_BASE_O <= `ETSS_RST_64;
            FS_LIMIT_O <= `ETSS_RST_32;
            GS_LIMIT_O <= `ETSS_RST_32;
            LIMIT_LOAD_O <= 1'b0;
            DEBUG_EN_O <= 1'b0;
        end else begin
            ENTRY_OK_O <= entry_ok;
            ENTRY_FAIL_O <= ENTRY_OP_I & ~entry_ok;
            LIMIT_LOAD_O <= entry_ok & mode32;
            DEBUG_EN_O <= dbg_opt_in;
            if (entry_ok) begin
                ENTRY_ADDR_O <= entry_addr;
                FS_BASE_O <= fs_base;
                GS_BASE_O <= gs_base;
            end
            if (entry_ok && mode32) begin
                FS_LIMIT_O <= fslim;
                GS_LIMIT_O <= gslim;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exit save layout and resume

    // Addresses use the index before the exit bumps it
    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            SAVE_O <= 1'b0;
            EXTENDED_STATE_REGION_ADDR_O <= `ETSS_RST_64;
            MISC_ADDR_O <= `ETSS_RST_64;
            MISC_VALID_O <= 1'b0;
            GPR_ADDR_O <= `ETSS_RST_64;
            RESUME_OK_O <= 1'b0;
            RESUME_FAIL_O <= 1'b0;
        end else begin
            SAVE_O <= AEX_OP_I & ~add_op;
            RESUME_OK_O <= resume_ok & ~add_op & ~AEX_OP_I;
            RESUME_FAIL_O <= RESUME_OP_I & ~resume_ok;
            if (AEX_OP_I && !add_op) begin
                EXTENDED_STATE_REGION_ADDR_O <= frame_addr;
                GPR_ADDR_O <= gpr_addr;
                MISC_ADDR_O <= misc_addr;
                MISC_VALID_O <= misc_valid;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug read of the exit pointer, only for debug enclaves

    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            DBG_RDATA_O <= `ETSS_RST_64;
            DBG_RVALID_O <= 1'b0;
            DBG_RERR_O <= 1'b0;
        end else begin
            DBG_RVALID_O <= DEBUG_READ_OP_I & dbg_attr;
            DBG_RERR_O <= DEBUG_READ_OP_I & ~dbg_attr;
            if (DEBUG_READ_OP_I && dbg_attr) begin
                DBG_RDATA_O <= async_exit_pointer;
            end
        end
    end

endmodule

// ### etss_thread_ctl_checker.sv
`timescale 1ns/1ps
module etss_thread_ctl_checker (
    // Clock and reset
    input wire MCLK_I,
    input wire RST_B_I,
    // Operation strobes
    input wire ENTRY_OP_I,
    input wire RESUME_OP_I,
    input wire AEX_OP_I,
    input wire PAGE_ADD_OP_I,
    input wire PAGE_ACCEPT_OP_I,
    input wire DEBUG_READ_OP_I,
    // Results
    input wire ENTRY_OK_O,
    input wire ENTRY_FAIL_O,
    input wire LIMIT_LOAD_O,
    input wire SAVE_O,
    input wire [63:0] EXTENDED_STATE_REGION_ADDR_O,
    input wire [63:0] MISC_ADDR_O,
    input wire MISC_VALID_O,
    input wire [63:0] GPR_ADDR_O,
    input wire RESUME_OK_O,
    input wire RESUME_FAIL_O,
    input wire DBG_RVALID_O,
    input wire DBG_RERR_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);

    // Frame span implied by the save outputs; top of frame less region base
    wire [63:0] frame_bytes = GPR_ADDR_O + 64'h0000_0000_0000_00B0 - EXTENDED_STATE_REGION_ADDR_O;

    ////////////////////////////////////////////////////////////////////////////////
    property p_entry_answer;
        ENTRY_OP_I |=> (ENTRY_OK_O != ENTRY_FAIL_O);
    endproperty
    a_entry_answer: assert property (p_entry_answer)
        else $error("entry gave no single verdict");
    property p_entry_quiet;
        !ENTRY_OP_I |=> !ENTRY_OK_O && !ENTRY_FAIL_O;
    endproperty
    a_entry_quiet: assert property (p_entry_quiet)
        else $error("entry verdict without request");
    property p_limit_load;
        LIMIT_LOAD_O |-> ENTRY_OK_O;
    endproperty
    a_limit_load: assert property (p_limit_load)
        else $error("limit load outside a good entry");
    property p_save_on_exit;
        AEX_OP_I && !PAGE_ADD_OP_I && !PAGE_ACCEPT_OP_I |=> SAVE_O;
    endproperty
    a_save_on_exit: assert property (p_save_on_exit)
        else $error("exit without state save");
    property p_save_quiet;
        !AEX_OP_I |=> !SAVE_O;
    endproperty
    a_save_quiet: assert property (p_save_quiet)
        else $error("state save without exit");
    property p_gpr_top;
        SAVE_O |-> frame_bytes[11:0] == 12'h000 && frame_bytes != 64'h0000_0000_0000_0000;
    endproperty
    a_gpr_top: assert property (p_gpr_top)
        else $error("register region not at frame top");
    property p_misc_below;
        SAVE_O && MISC_VALID_O |-> MISC_ADDR_O < GPR_ADDR_O && MISC_ADDR_O >= EXTENDED_STATE_REGION_ADDR_O;
    endproperty
    a_misc_below: assert property (p_misc_below)
        else $error("misc region misplaced");
    property p_frame_step;
        SAVE_O && $past(SAVE_O) |-> EXTENDED_STATE_REGION_ADDR_O == $past(EXTENDED_STATE_REGION_ADDR_O) + frame_bytes;
    endproperty
    a_frame_step: assert property (p_frame_step)
        else $error("back to back saves not one frame apart");
    property p_resume_answer;
        RESUME_OP_I |=> (RESUME_OK_O != RESUME_FAIL_O);
    endproperty
    a_resume_answer: assert property (p_resume_answer)
        else $error("resume gave no single verdict");
    property p_dbg_answer;
        DEBUG_READ_OP_I |=> (DBG_RVALID_O != DBG_RERR_O);
    endproperty
    a_dbg_answer: assert property (p_dbg_answer)
        else $error("debug read gave no single verdict");
endmodule

bind etss_thread_ctl etss_thread_ctl_checker u_chk (.MCLK_I, .RST_B_I, .ENTRY_OP_I, .RESUME_OP_I, .AEX_OP_I,
    .PAGE_ADD_OP_I, .PAGE_ACCEPT_OP_I, .DEBUG_READ_OP_I, .ENTRY_OK_O, .ENTRY_FAIL_O, .LIMIT_LOAD_O, .SAVE_O,
    .EXTENDED_STATE_REGION_ADDR_O, .MISC_ADDR_O, .MISC_VALID_O, .GPR_ADDR_O, .RESUME_OK_O, .RESUME_FAIL_O, .DBG_RVALID_O,
    .DBG_RERR_O);

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    logic mclk, rst_b, psel, penable, pwrite, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, q;
    logic [5:0] opv;
    logic [63:0] async_exit_pointer;
    wire [31:0] prdata, fs_lim, gs_lim;
    wire pready, pslverr, ok, fail, lload, dbg_en, save, mvalid, r_ok, r_fail, d_valid, d_err;
    wire [63:0] eaddr, fs, gs, xaddr, maddr, gaddr, drdata;
    int err_total, check_count;
    localparam logic [63:0] EBASE = 64'h0000_0001_0000_0000;
    localparam logic [63:0] SAVE_STACK_OFFSET = 64'h0000_0000_0001_0000;
    localparam logic [63:0] F0 = EBASE + SAVE_STACK_OFFSET;
    localparam logic [63:0] FB = 64'h0000_0000_0000_2000;
    localparam logic [63:0] AEPV = 64'h1234_5678_9ABC_DEF0;

    etss_thread_ctl dut (.MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .ENTRY_OP_I(opv[0]), .RESUME_OP_I(opv[1]), .AEX_OP_I(opv[2]), .PAGE_ADD_OP_I(opv[3]),
        .PAGE_ACCEPT_OP_I(opv[4]), .DEBUG_READ_OP_I(opv[5]), .AEP_I(async_exit_pointer), .ENTRY_OK_O(ok), .ENTRY_FAIL_O(fail),
        .ENTRY_ADDR_O(eaddr), .FS_BASE_O(fs), .GS_BASE_O(gs), .FS_LIMIT_O(fs_lim), .GS_LIMIT_O(gs_lim),
        .LIMIT_LOAD_O(lload), .DEBUG_EN_O(dbg_en), .SAVE_O(save), .EXTENDED_STATE_REGION_ADDR_O(xaddr), .MISC_ADDR_O(maddr),
        .MISC_VALID_O(mvalid), .GPR_ADDR_O(gaddr), .RESUME_OK_O(r_ok), .RESUME_FAIL_O(r_fail),
        .DBG_RDATA_O(drdata), .DBG_RVALID_O(d_valid), .DBG_RERR_O(d_err));

    // Clock
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [63:0] ex, input logic [63:0] got);
        check_count++;
        if (got !== ex) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, ex, got);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        // No assumed latency; a slave that never answers is caught by the watchdog
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task w64(input logic [7:0] a, input logic [63:0] v);
        apb(1, a, v[31:0]);
        apb(1, a + 8'h04, v[63:32]);
    endtask
    // One-cycle operation strobe; returns once its result is settled
    task pulse(input int k);
        @(posedge mclk);
        opv[k] <= 1'b1;
        @(posedge mclk);
        opv <= 6'h00;
        #1;
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        apb(0, 8'h18, 0); chk("index", 0, q);
        apb(1, 8'h88, 0); apb(0, 8'h88, 0); chk("frame pages", 1, q);
        apb(0, 8'h50, 0); chk("unmapped", 64'h1_0000_0000, {e, q});
        apb(1, 8'hA8, 32'h1234_5FFF); apb(0, 8'hA8, 0);
        chk("record base", 32'h1234_5000, q);
    endtask
    task t_entry;
        w64(8'h80, EBASE); w64(8'h10, SAVE_STACK_OFFSET); w64(8'h20, 64'h2000); w64(8'h30, 64'h3000); w64(8'h38, 64'h4000);
        apb(1, 8'h40, 32'h0000_0FFF); apb(1, 8'h44, 32'h0000_1FFF); apb(1, 8'h88, 2); apb(1, 8'h1C, 2);
        apb(1, 8'h90, 1); apb(1, 8'h94, 32'h0000_0040);
        async_exit_pointer <= AEPV;
        pulse(0);
        chk("entry ok", 1, ok);
        chk("entry addr", EBASE + 64'h2000, eaddr);
        chk("fs base", EBASE + 64'h3000, fs);
        chk("gs base", EBASE + 64'h4000, gs);
        chk("limit load", 1, lload);
        chk("limits", {32'h0000_0FFF, 32'h0000_1FFF}, {fs_lim, gs_lim});
        apb(0, 8'h28, 0); chk("aep lo", AEPV[31:0], q);
        apb(0, 8'h2C, 0); chk("aep hi", AEPV[63:32], q);
        pulse(5); chk("dbg denied", 1, d_err);
        apb(1, 8'h8C, 2); pulse(5); chk("dbg read", 1, d_valid);
        chk("dbg data", AEPV, drdata);
    endtask
    // Back-to-back exits, then entry with every frame in use
    task t_exit;
        @(posedge mclk);
        opv[2] <= 1'b1;
        @(posedge mclk);
        #1;
        chk("save0", 1, save);
        chk("xsave0", F0, xaddr);
        chk("gpr0", F0 + FB - 64'h00B0, gaddr);
        chk("misc valid0", 1, mvalid);
        chk("misc0", F0 + FB - 64'h00F0, maddr);
        @(posedge mclk);
        opv <= 6'h00;
        #1;
        chk("save1", 1, save);
        chk("xsave1", F0 + FB, xaddr);
        apb(0, 8'h18, 0); chk("index up", 2, q);
        apb(0, 8'hA0, 0); chk("frame addr", 32'h0001_4000, q);
        pulse(0); chk("entry full", 1, fail);
        apb(0, 8'h9C, 0); chk("fail flag", 1, q[0]);
    endtask
    task t_resume;
        for (int i = 0; i < 3; i++) begin
            pulse(1); chk("resume", {i < 2, i == 2}, {r_ok, r_fail});
        end
        apb(0, 8'h18, 0); chk("index down", 0, q);
    endtask
    task t_flags;
        apb(1, 8'h8C, 0); apb(1, 8'h08, 1); apb(0, 8'h08, 0); chk("opt-in locked", 0, q);
        apb(1, 8'h8C, 2); apb(1, 8'h08, 1); apb(0, 8'h08, 0); chk("opt-in set", 1, q);
        chk("debug on", 1, dbg_en);
        apb(1, 8'h18, 1); pulse(4); apb(0, 8'h18, 0); chk("accept index", 0, q);
        apb(0, 8'h08, 0); chk("accept keeps", 1, q);
        apb(1, 8'h18, 1); pulse(3); apb(0, 8'h18, 0); chk("add index", 0, q);
        apb(0, 8'h08, 0); chk("add clears", 0, q);
        chk("debug off", 0, dbg_en);
        apb(1, 8'h9C, 32'h0000_001F); apb(1, 8'h30, 32'h0000_3010);
        apb(1, 8'h98, 32'h0000_2000); apb(0, 8'h9C, 0);
        chk("misalign", 1, q[1]);
        chk("overlap", 1, q[2]);
        apb(1, 8'h8C, 32'h0000_0006); pulse(0);
        chk("entry 64-bit", 2'b10, {ok, lload});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; opv = 0; async_exit_pointer = 0;
        err_total = 0; check_count = 0;
        repeat (4) @(posedge mclk);
        rst_b <= 1;
        t_reset; t_entry; t_exit; t_resume; t_flags;
        test_done;
    end
    // Hang guard, well beyond the expected run
    initial begin
        #200000;
        err_total++;
        test_done;
    end
endmodule
